// file: core/edr_pkg.sv
// Package for the EXTENDED_OUTPUT_PAGE_MODE DRAM host controller: timing counts and carriers.
// Assumes a 125 MHz controller clock (8 ns period).
package edr_pkg;

  // ===========================================================
  // Clock and timing figures.
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned T_RAS_NS = 60;
  localparam int unsigned T_RP_NS = 40;
  localparam int unsigned T_RCD_NS = 14;
  localparam int unsigned T_AR_NS = 40;
  localparam int unsigned T_RAC_NS = 60;
  localparam int unsigned T_CAS_NS = 15;
  localparam int unsigned T_CP_NS = 10;
  localparam int unsigned T_CSR_NS = 10;
  localparam int unsigned T_WAKE_US = 200;
  localparam int unsigned T_REF_MS = 16;
  localparam int unsigned WAKE_CYCLES_NUM = 8;
  localparam int unsigned REF_ROWS = 1024;

  // Least times round up to whole cycles, none below one.
  function automatic int unsigned up_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned RAS_CYC = up_cyc(T_RAS_NS);
  localparam int unsigned RP_CYC = up_cyc(T_RP_NS);
  localparam int unsigned RCD_CYC = up_cyc(T_RCD_NS);
  localparam int unsigned AR_CYC = up_cyc(T_AR_NS);
  localparam int unsigned RAC_CYC = up_cyc(T_RAC_NS);
  localparam int unsigned CAS_CYC = up_cyc(T_CAS_NS);
  localparam int unsigned CP_CYC = up_cyc(T_CP_NS);
  localparam int unsigned CSR_CYC = up_cyc(T_CSR_NS);
  localparam int unsigned WAKE_CYC = T_WAKE_US * 125;
  // Longest time between refreshes rounds down.
  localparam int unsigned REF_INT_CYC = (T_REF_MS * 125000) / REF_ROWS;

  // ===========================================================
  // Pin bundle towards the DRAM.
  typedef struct packed {
    logic row_strobe_n;
    logic lower_byte_strobe_n;
    logic upper_byte_strobe_n;
    logic write_n;
    logic out_gate_n;
    logic [9:0] multiplexed_address_inputs;
  } edr_pins_t;

  // User request carrier.
  typedef struct packed {
    logic write;
    logic [1:0] byte_en;
    logic [9:0] row;
    logic [9:0] col;
    logic [15:0] wdata;
  } edr_req_t;

  localparam edr_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 10'h000};

endpackage

// file: core/edr_ctrl.sv
// Host-side controller that drives an asynchronous 1M x 16 EXTENDED_OUTPUT_PAGE_MODE DRAM.
// Assumes the DRAM pins are fed from flip-flops and data returns async.
//
// What this block does
// - A cycle opens at row strobe low, ends when row and column go high.
// - Never end a cycle before the least row-low time has passed.
// - Wait the least precharge time after a cycle before another.
// - Read begins at later of column strobe or gate fall, write high.
// - Hold the column address at least the hold time from row strobe.
// - Write begins at later of column strobe or write strobe fall.
// - Write data valid no later than earlier of those two falls.
// - Issue 1,024 refresh cycles within every 16 ms.
// - Column-first refresh starts when row falls with column held low.
// - Self refresh: column-first refresh, then hold row low past row time.
// - Self refresh ends with row strobe high for the precharge time.
// - After self refresh with burst refresh, refresh all 1,024 rows.
// - Reads and writes may mix within one row strobe cycle.
// - After power-up wait 200 us then at least eight row cycles.
// - Hold row strobe at valid high during power-on.
// - Row and column share ten address inputs, latched by strobes.
// - Column-first refresh holds at least one byte column strobe low.
`timescale 1ns/1ps
`default_nettype none

module edr_ctrl #(
  parameter int unsigned WAKE_CYC = edr_pkg::WAKE_CYC,
  parameter int unsigned REF_INT_CYC = edr_pkg::REF_INT_CYC,
  parameter int unsigned WAKE_CYCLES = edr_pkg::WAKE_CYCLES_NUM
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // User request port.
  input wire logic i_req_valid,
  input wire edr_pkg::edr_req_t i_req,
  input wire logic i_page_keep,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data,
  output logic o_init_done,
  // Self refresh control.
  input wire logic i_self_refresh,
  output logic o_in_self_refresh,
  // DRAM pins.
  output edr_pkg::edr_pins_t o_pins,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic [1:0] o_dq_oe
);

  initial begin
    if (WAKE_CYCLES < 8 || WAKE_CYC < 1 || REF_INT_CYC < 64) begin
      $error("edr_ctrl: parameter out of range");
    end
  end

  // ===========================================================
  // State encoding.
  typedef enum logic [3:0] {
    ST_WAKE = 4'h0, ST_IDLE = 4'h1, ST_ROW = 4'h2, ST_COL = 4'h3,
    ST_CASH = 4'h4, ST_CLOSE = 4'h5, ST_PRE = 4'h6, ST_CBR_C = 4'h7,
    ST_CBR_R = 4'h8, ST_SELF = 4'h9, ST_SELF_X = 4'hA
  } edr_state_t;

  edr_state_t state, next_state;
  edr_pkg::edr_pins_t next_pins;
  logic [15:0] next_dq, next_rd_data;
  logic [1:0] next_dq_oe;
  logic next_rd_valid, next_ready, next_init_done, next_self;
  logic [15:0] cnt, next_cnt;      // Phase counter.
  logic [15:0] low_cnt, next_low_cnt;  // Cycles since row strobe fell.
  logic [14:0] ref_cnt, next_ref_cnt;
  logic [10:0] ref_due, next_ref_due;  // Outstanding refreshes.
  logic [3:0] wake_left, next_wake_left;
  logic is_wr, next_is_wr;
  logic [9:0] open_row, next_open_row;
  logic [1:0] be, next_be;
  logic [15:0] dq_s1, dq_s2;
  logic rd_pend, next_rd_pend;

  // Read data comes from an asynchronous part: two flops first.
  always_ff @(posedge i_ref_clk) begin
    dq_s1 <= i_dq;
    dq_s2 <= dq_s1;
  end

  // Next-state and pin computation.
  always_comb begin
    next_state = state;
    next_pins = o_pins;
    next_dq = o_dq;
    next_dq_oe = o_dq_oe;
    next_rd_data = o_rd_data;
    next_rd_valid = 1'b0;
    next_ready = 1'b0;
    next_init_done = o_init_done;
    next_self = o_in_self_refresh;
    next_cnt = (cnt == 16'hFFFF) ? cnt : cnt + 16'h0001;
    next_low_cnt = o_pins.row_strobe_n ? 16'h0000 :
      ((low_cnt == 16'hFFFF) ? low_cnt : low_cnt + 16'h0001);
    next_ref_due = ref_due;
    next_wake_left = wake_left;
    next_is_wr = is_wr;
    next_open_row = open_row;
    next_be = be;
    next_rd_pend = rd_pend;
    // Distributed refresh tick: 1,024 per 16 ms.
    if (ref_cnt >= 15'(REF_INT_CYC - 1)) begin
      next_ref_cnt = 15'h0000;
      if (o_init_done && !o_in_self_refresh &&
          ref_due != 11'h7FF) begin
        next_ref_due = ref_due + 11'h001;
      end
    end else begin
      next_ref_cnt = ref_cnt + 15'h0001;
    end
    case (state)
      // Power-on pause with row strobe held high.
      ST_WAKE: begin
        next_pins = edr_pkg::PINS_IDLE;
        if (cnt >= 16'(WAKE_CYC - 1)) begin
          next_state = ST_PRE;
          next_cnt = 16'h0000;
          next_wake_left = 4'(WAKE_CYCLES);
        end
      end
      ST_IDLE: begin
        if (wake_left != 4'h0 || ref_due != 11'h000 || i_self_refresh) begin
          next_pins.lower_byte_strobe_n = 1'b0;
          next_pins.upper_byte_strobe_n = 1'b0;
          next_state = ST_CBR_C;
          next_cnt = 16'h0000;
        end else if (i_req_valid) begin
          next_pins.multiplexed_address_inputs = i_req.row;
          next_open_row = i_req.row;
          next_state = ST_ROW;
          next_cnt = 16'h0000;
        end
      end
      // Address setup is one cycle; now drop row strobe.
      ST_ROW: begin
        next_pins.row_strobe_n = 1'b0;
        next_ready = 1'b1;
        next_state = ST_CASH;
        next_cnt = 16'h0000;
      end
      // Row open, column strobes high: take a page access or close.
      ST_CASH: begin
        if (cnt >= 16'(edr_pkg::RCD_CYC - 1) && o_req_ready == 1'b0 &&
            i_req_valid && i_req.row == open_row && ref_due == 11'h000) begin
          next_is_wr = i_req.write;
          next_be = i_req.byte_en;
          next_pins.multiplexed_address_inputs = i_req.col;
          next_pins.write_n = ~i_req.write;
          next_pins.out_gate_n = i_req.write;
          next_dq = i_req.wdata;
          next_dq_oe = i_req.write ? i_req.byte_en : 2'b00;
          next_state = ST_COL;
          next_cnt = 16'h0000;
        end else if (cnt >= 16'(edr_pkg::CP_CYC - 1) && !o_req_ready &&
            !(i_req_valid && i_req.row == open_row && i_page_keep &&
            ref_due == 11'h000)) begin
          // A pending refresh closes a kept page so the row cannot starve it.
          next_state = ST_CLOSE;
        end
        next_ready = 1'b0;
      end
      // Enabled byte column strobes fall together; data already placed.
      ST_COL: begin
        if (cnt == 16'h0000) begin
          next_pins.lower_byte_strobe_n = ~be[0];
          next_pins.upper_byte_strobe_n = ~be[1];
          next_rd_pend = ~is_wr;
        end else if (cnt >= 16'(edr_pkg::CAS_CYC + 2) &&
            low_cnt >= 16'(edr_pkg::RAC_CYC + 2)) begin
          // Wait covers access limits plus synchroniser depth.
          if (rd_pend) begin
            next_rd_data = dq_s2;
            next_rd_valid = 1'b1;
          end
          next_rd_pend = 1'b0;
          next_pins.lower_byte_strobe_n = 1'b1;
          next_pins.upper_byte_strobe_n = 1'b1;
          next_pins.write_n = 1'b1;
          next_dq_oe = 2'b00;
          next_ready = 1'b1;
          next_state = ST_CASH;
          next_cnt = 16'h0000;
        end
      end
      // Hold row low through row-low and column hold time.
      ST_CLOSE: begin
        if (low_cnt >= 16'(edr_pkg::RAS_CYC) &&
            low_cnt >= 16'(edr_pkg::AR_CYC)) begin
          next_pins = edr_pkg::PINS_IDLE;
          next_pins.multiplexed_address_inputs = open_row;
          next_state = ST_PRE;
          next_cnt = 16'h0000;
        end
      end
      // Precharge before any new cycle.
      ST_PRE: begin
        next_pins = edr_pkg::PINS_IDLE;
        if (cnt >= 16'(edr_pkg::RP_CYC - 1)) begin
          next_state = ST_IDLE;
          if (wake_left == 4'h0 && !o_init_done) begin
            next_init_done = 1'b1;
          end
        end
      end
      // Column strobes low ahead of row strobe; outputs stay off.
      ST_CBR_C: begin
        next_dq_oe = 2'b00;
        if (cnt >= 16'(edr_pkg::CSR_CYC - 1)) begin
          next_pins.row_strobe_n = 1'b0;
          next_state = ST_CBR_R;
          next_cnt = 16'h0000;
        end
      end
      ST_CBR_R: begin
        if (low_cnt >= 16'(edr_pkg::RAS_CYC)) begin
          if (i_self_refresh && wake_left == 4'h0) begin
            next_state = ST_SELF;
            next_self = 1'b1;
          end else begin
            next_pins = edr_pkg::PINS_IDLE;
            next_state = ST_PRE;
            next_cnt = 16'h0000;
            if (wake_left != 4'h0) begin
              next_wake_left = wake_left - 4'h1;
            end else if (ref_due != 11'h000) begin
              next_ref_due = ref_due - 11'h001;
            end
          end
        end
      end
      // Self refresh: row and column strobes stay low.
      ST_SELF: begin
        if (!i_self_refresh) begin
          next_pins = edr_pkg::PINS_IDLE;
          next_state = ST_PRE;
          next_cnt = 16'h0000;
          next_self = 1'b0;
          // Distributed refresh resumes; no burst needed.
          next_ref_due = 11'h000;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state <= ST_WAKE;
      o_pins <= edr_pkg::PINS_IDLE;
      o_dq <= 16'h0000;
      o_dq_oe <= 2'b00;
      o_rd_data <= 16'h0000;
      o_rd_valid <= 1'b0;
      o_req_ready <= 1'b0;
      o_init_done <= 1'b0;
      o_in_self_refresh <= 1'b0;
      cnt <= 16'h0000;
      low_cnt <= 16'h0000;
      ref_cnt <= 15'h0000;
      ref_due <= 11'h000;
      wake_left <= 4'h0;
      is_wr <= 1'b0;
      open_row <= 10'h000;
      be <= 2'b00;
      rd_pend <= 1'b0;
    end else begin
      state <= next_state;
      o_pins <= next_pins;
      o_dq <= next_dq;
      o_dq_oe <= next_dq_oe;
      o_rd_data <= next_rd_data;
      o_rd_valid <= next_rd_valid;
      o_req_ready <= next_ready;
      o_init_done <= next_init_done;
      o_in_self_refresh <= next_self;
      cnt <= next_cnt;
      low_cnt <= next_low_cnt;
      ref_cnt <= next_ref_cnt;
      ref_due <= next_ref_due;
      wake_left <= next_wake_left;
      is_wr <= next_is_wr;
      open_row <= next_open_row;
      be <= next_be;
      rd_pend <= next_rd_pend;
    end
  end

  // ===========================================================
  // Checks.
  sequence row_rise;
    !$past(o_pins.row_strobe_n) && o_pins.row_strobe_n;
  endsequence

  AST_RAS_MIN: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    row_rise |-> $past(low_cnt) >= 16'(edr_pkg::RAS_CYC))
    else $error("Row strobe rose before least row-low time.");

  AST_PRECHARGE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    row_rise |=> o_pins.row_strobe_n [*5])
    else $error("Row strobe fell again before precharge ended.");

  AST_WR_DATA: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $fell(o_pins.lower_byte_strobe_n) && !o_pins.write_n
    |-> o_dq_oe[0])
    else $error("Write data not driven at column strobe fall.");

  AST_READ_GATE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_dq_oe != 2'b00 |-> !o_pins.write_n && o_pins.out_gate_n)
    else $error("Data driven while device may drive outputs.");

  AST_CBR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $fell(o_pins.row_strobe_n) && !o_pins.lower_byte_strobe_n
    |-> $past(!o_pins.lower_byte_strobe_n) && o_dq_oe == 2'b00)
    else $error("Column-first refresh without column strobe held.");

  AST_WAKE_HIGH: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !o_init_done && state == ST_WAKE |-> o_pins.row_strobe_n)
    else $error("Row strobe low during power-on pause.");

  AST_RD_AFTER_ROW: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_rd_valid |-> low_cnt > 16'(edr_pkg::RAC_CYC))
    else $error("Read data taken before row access time.");

  AST_ADDR_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $fell(o_pins.row_strobe_n) && o_pins.lower_byte_strobe_n
    |=> $stable(o_pins.multiplexed_address_inputs))
    else $error("Row address changed right after row strobe fell.");

endmodule

`default_nettype wire

// file: testbench/edr_dram_model.sv
// Behavioural model of the EXTENDED_OUTPUT_PAGE_MODE DRAM that the controller drives.
// Assumes pins from edr_ctrl and a resolved data bus from the bench.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// DRAM model with timing monitors
module edr_dram_model (
  // Pins from the controller.
  input wire edr_pkg::edr_pins_t i_pins,
  input wire logic [15:0] i_dq,
  input wire logic [1:0] i_dq_oe,
  // Read data and monitor counts.
  output logic [15:0] o_dq,
  output logic [1:0] o_drive,
  output int o_viol,
  output int o_refresh,
  output int o_row_cycles
);
  logic [15:0] mem [int];
  logic [9:0] row;
  logic [9:0] col;
  logic [15:0] rd_word;
  logic [1:0] rd_bytes;
  logic [1:0] byte_n;
  logic col_n;
  logic col_open;
  logic in_refresh;
  logic rd_held;
  realtime t_fall;
  realtime t_rise;
  realtime dly;

  // The internal column strobe spans first fall to last rise.
  assign byte_n = {i_pins.upper_byte_strobe_n, i_pins.lower_byte_strobe_n};
  assign col_n = &byte_n;
  // Drive only read bytes with the gate low; no drive in refresh.
  assign o_drive = (rd_held && !i_pins.out_gate_n && !in_refresh &&
    !(i_pins.row_strobe_n && col_n)) ? rd_bytes : 2'b00;
  // A released byte shows the inverse of the data, never a stale copy.
  assign o_dq = {o_drive[1] ? rd_word[15:8] : ~rd_word[15:8],
    o_drive[0] ? rd_word[7:0] : ~rd_word[7:0]};

  // Monitor counters start clear.
  initial begin
    o_viol = 0;
    o_refresh = 0;
    o_row_cycles = 0;
    col_open = 1'b0;
    rd_held = 1'b0;
    in_refresh = 1'b0;
    rd_word = 16'h0000;
    t_rise = -1000.0;
  end

  // Row strobe fall opens a cycle or a column-first refresh.
  always @(negedge i_pins.row_strobe_n) begin
    if ($realtime - t_rise < 40.0) o_viol++;
    t_fall = $realtime;
    o_row_cycles++;
    in_refresh = !col_n;
    if (in_refresh) o_refresh++;
    else row = i_pins.multiplexed_address_inputs;
  end

  // Row strobe rise may not come before the least row-low time.
  always @(posedge i_pins.row_strobe_n) begin
    if (o_row_cycles > 0 && $realtime - t_fall < 60.0) o_viol++;
    t_rise = $realtime;
    if (col_n) rd_held = 1'b0;
  end

  // Last byte strobe rise closes the column.
  always @(posedge col_n) begin
    col_open = 1'b0;
    if (i_pins.row_strobe_n) rd_held = 1'b0;
  end

  // Column fall latches the column; reads and writes start here.
  always @(negedge i_pins.lower_byte_strobe_n or
      negedge i_pins.upper_byte_strobe_n or negedge i_pins.write_n) begin
    if (!i_pins.row_strobe_n && !in_refresh && !col_n) begin
      if (!col_open) begin
        col_open = 1'b1;
        col = i_pins.multiplexed_address_inputs;
        rd_held = 1'b0;
        if (i_pins.write_n) begin
          dly = t_fall + 60.0 - $realtime;
          if (dly < 15.0) dly = 15.0;
          rd_bytes = ~byte_n;
          rd_word <= #(dly) mem.exists({row, col}) ? mem[{row, col}] :
            16'h0000;
          rd_held <= #(dly) 1'b1;
        end
      end
      if (!i_pins.write_n) begin
        for (int b = 0; b < 2; b++) begin
          if (!byte_n[b]) begin
            if (!i_dq_oe[b]) o_viol++;
            if (!mem.exists({row, col})) mem[{row, col}] = 16'h0000;
            mem[{row, col}][b*8 +: 8] = i_dq[b*8 +: 8];
          end
        end
      end
    end
  end
endmodule

`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for edr_ctrl against the DRAM model.
// Assumes edr_pkg and edr_ctrl are compiled first.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Top of the bench
module testbench;
  logic i_ref_clk;
  logic i_reset;
  logic i_req_valid;
  edr_pkg::edr_req_t i_req;
  logic i_page_keep;
  logic i_self_refresh;
  logic o_req_ready;
  logic o_rd_valid;
  logic [15:0] o_rd_data;
  logic o_init_done;
  logic o_in_self_refresh;
  edr_pkg::edr_pins_t o_pins;
  logic [15:0] i_dq;
  logic [15:0] o_dq;
  logic [1:0] o_dq_oe;
  logic [15:0] m_dq;
  int viol;
  int refresh;
  int rows;
  int error_cnt;
  int total_checks;
  int cycles;
  logic [15:0] rd;

  edr_ctrl #(.WAKE_CYC(50), .REF_INT_CYC(200), .WAKE_CYCLES(8)) i_dut (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_req_valid(i_req_valid),
    .i_req(i_req), .i_page_keep(i_page_keep), .o_req_ready(o_req_ready),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_init_done(o_init_done), .i_self_refresh(i_self_refresh),
    .o_in_self_refresh(o_in_self_refresh), .o_pins(o_pins), .i_dq(i_dq),
    .o_dq(o_dq), .o_dq_oe(o_dq_oe));

  edr_dram_model i_mem (.i_pins(o_pins), .i_dq(i_dq), .i_dq_oe(o_dq_oe),
    .o_dq(m_dq), .o_drive(), .o_viol(viol), .o_refresh(refresh),
    .o_row_cycles(rows));

  // Each byte of the bus carries whichever side drives it.
  assign i_dq = {o_dq_oe[1] ? o_dq[15:8] : m_dq[15:8],
    o_dq_oe[0] ? o_dq[7:0] : m_dq[7:0]};

  // Clock of 8 ns and a cycle counter that cuts a hang short.
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  // Compares one result and counts it.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Presents one request until its ready count and read data arrive.
  task automatic do_req(input logic wr, input logic [1:0] be,
      input logic [9:0] r, input logic [9:0] c, input logic [15:0] wd,
      input int need, output logic [15:0] q);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    q = 16'h0000;
    // A kept page returns at a falling edge with valid still high.
    if (i_req_valid !== 1'b1) @(negedge i_ref_clk);
    i_req = '{wr, be, r, c, wd};
    i_req_valid = 1'b1;
    for (int k = 0; k < 400 && (n < need || (!wr && !got)); k++) begin
      @(posedge i_ref_clk);
      #1;
      if (o_req_ready === 1'b1) n++;
      if (o_rd_valid === 1'b1) begin
        got = 1'b1;
        q = o_rd_data;
      end
      if (n == need && i_req_valid) begin
        @(negedge i_ref_clk);
        if (!i_page_keep) i_req_valid = 1'b0;
      end
    end
    check(32'(n), 32'(need));
  endtask

  // Wake-up pause then eight refresh cycles before init done.
  task automatic t_init();
    int k;
    check(32'(o_pins.row_strobe_n), 32'h1);
    for (k = 0; k < 2000 && o_init_done !== 1'b1; k++) @(posedge i_ref_clk);
    check(32'(rows >= 8), 32'h1);
    check(32'(cycles >= 58), 32'h1);
  endtask

  // Word write, lower byte write, then read back.
  task automatic t_rw();
    do_req(1'b1, 2'b11, 10'h003, 10'h007, 16'hA5C3, 2, rd);
    do_req(1'b1, 2'b01, 10'h003, 10'h007, 16'h1234, 2, rd);
    do_req(1'b0, 2'b11, 10'h003, 10'h007, 16'h0000, 2, rd);
    check(32'(rd), 32'h0000A534);
  endtask

  // Mixed writes and reads in one open row.
  task automatic t_page();
    int r0;
    // Start right after a refresh so none falls inside the page.
    r0 = refresh;
    for (int k = 0; k < 400 && refresh == r0; k++) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_page_keep = 1'b1;
    r0 = rows;
    do_req(1'b1, 2'b11, 10'h005, 10'h001, 16'h1111, 2, rd);
    do_req(1'b1, 2'b11, 10'h005, 10'h3FF, 16'h2222, 1, rd);
    do_req(1'b0, 2'b11, 10'h005, 10'h001, 16'h0000, 1, rd);
    check(32'(rd), 32'h00001111);
    do_req(1'b0, 2'b10, 10'h005, 10'h3FF, 16'h0000, 1, rd);
    check(32'(rd[15:8]), 32'h22);
    check(32'(rows - r0), 32'h1);
    i_req_valid = 1'b0;
    i_page_keep = 1'b0;
  endtask

  // Idle time must still see distributed refreshes.
  task automatic t_refresh();
    int r0;
    r0 = refresh;
    repeat (700) @(posedge i_ref_clk);
    check(32'(refresh - r0 >= 3), 32'h1);
  endtask

  // Enter and leave self refresh, then access again.
  task automatic t_self();
    int k;
    @(negedge i_ref_clk);
    i_self_refresh = 1'b1;
    for (k = 0; k < 200 && o_in_self_refresh !== 1'b1; k++)
      @(posedge i_ref_clk);
    repeat (20) @(posedge i_ref_clk);
    check(32'(o_pins.row_strobe_n), 32'h0);
    check(32'(o_pins.lower_byte_strobe_n & o_pins.upper_byte_strobe_n),
      32'h0);
    @(negedge i_ref_clk);
    i_self_refresh = 1'b0;
    for (k = 0; k < 200 && o_in_self_refresh !== 1'b0; k++)
      @(posedge i_ref_clk);
    do_req(1'b0, 2'b11, 10'h003, 10'h007, 16'h0000, 2, rd);
    check(32'(rd), 32'h0000A534);
  endtask

  // Main sequence: reset, scenarios, monitor count, verdict.
  initial begin
    i_reset = 1'b1;
    i_req_valid = 1'b0;
    i_req = '0;
    i_page_keep = 1'b0;
    i_self_refresh = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    cycles = 0;
    repeat (8) @(negedge i_ref_clk);
    i_reset = 1'b0;
    t_init();
    t_rw();
    t_page();
    t_refresh();
    t_self();
    check(32'(viol), 32'h0);
    complete_run();
  end
endmodule

`default_nettype wire
